// file: rtl/cal_ctrl_pkg.sv
// constants, field positions and reset values of the gain and offset calibration control
package cal_ctrl_pkg;

	// system clock
	localparam int unsigned SYS_CLK_KHZ = 10000;

	// serial word framing
	localparam int unsigned WORD_W    = 32;
	localparam int unsigned ADDR_LSB  = 0;
	localparam int unsigned BANK_LSB  = 3;
	localparam logic [2:0]  ADDR_RB   = 3'h0;
	localparam logic [2:0]  ADDR_REG1 = 3'h1;
	localparam logic [2:0]  ADDR_REG2 = 3'h2;
	localparam logic [1:0]  BANK_MAIN = 2'h1;

	// setup register 1
	localparam logic [31:0] REG1_RESET     = 32'h0100_FC89;
	localparam int unsigned GAIN_LSB       = 12;
	localparam int unsigned RES_BYP_BIT    = 25;
	localparam int unsigned CAP_BYP_BIT    = 26;
	localparam int unsigned EXT_RED_EN_BIT = 27;
	localparam int unsigned GAIN_X2_BIT    = 28;
	localparam int unsigned OSC_PROBE_BIT  = 29;

	// setup register 2
	localparam logic [31:0] REG2_RESET    = 32'h71E0_200A;
	localparam int unsigned TRIGGER_BIT   = 5;
	localparam int unsigned I_MAN_LSB     = 6;
	localparam int unsigned Q_MAN_LSB     = 14;
	localparam int unsigned FS_SEL_LSB    = 22;
	localparam int unsigned CAL_MODE_BIT  = 24;
	localparam int unsigned DIV_SEL_LSB   = 25;
	localparam int unsigned CLK_SRC_BIT   = 28;
	localparam int unsigned OSC_TRIM_LSB  = 29;

	// readback register
	localparam logic [31:0] RB_OFFSET    = 32'h0000_0000;
	localparam int unsigned VERSION_LSB  = 5;
	localparam int unsigned Q_RB_LSB     = 16;
	localparam int unsigned I_RB_LSB     = 24;

	// gain range and correction start value
	localparam logic [4:0] GAIN_MAX     = 5'h18;
	localparam logic [7:0] CORR_RESET   = 8'h80;

	// a run settles once, then decides one bit per divided tick
	localparam logic [3:0] CAL_STEPS    = 4'h9;

	// divider ratio per code
	localparam int unsigned DIV_W = 15;
	localparam logic [DIV_W-1:0] DIV_RATIO [8] = '{
		15'h0001, 15'h0008, 15'h0010, 15'h0080,
		15'h0100, 15'h0400, 15'h0800, 15'h412C
	};

	// nominal oscillator frequency per trim code
	localparam int unsigned OSC_KHZ [8] = '{300, 500, 700, 900, 1100, 1300, 1500, 1800};

	// half period of the modelled oscillator in system clocks, at least one
	function automatic logic [DIV_W-1:0] osc_half_cycles(input logic [2:0] trim);
		int unsigned c;
		c = SYS_CLK_KHZ / (2 * OSC_KHZ[trim]);
		if (c < 1)
			c = 1;
		return c[DIV_W-1:0];
	endfunction

endpackage

// file: rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
module pin_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and control
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// pin and filtered level
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_t;

	sync_t st_ff;
	sync_t nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = pin;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		// first stage feeds only the second; change counts once two later stages agree
		if (st_ff.s2 == st_ff.s3)
			nxt_st.lvl = st_ff.s3;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			st_ff <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
		else if (clk_en)
			st_ff <= nxt_st;
	end

	assign level = st_ff.lvl;
endmodule

// file: rtl/tick_divider.sv
// counts input ticks and pulses once every limit ticks
module tick_divider #(
	parameter int unsigned W = 15
) (
	// clock and control
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	input  wire logic         clear,
	// tick stream
	input  wire logic         tick_in,
	input  wire logic [W-1:0] limit,
	output logic              pulse
);
	if (W < 1 || W > 31) begin : g_bad_width
		$error("tick_divider width out of range");
	end

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         pls;
	} div_t;

	div_t st_ff;
	div_t nxt_st;

	always_comb begin
		nxt_st     = st_ff;
		nxt_st.pls = 1'b0;
		if (clear) begin
			nxt_st.cnt = '0;
		end else if (tick_in) begin
			// a limit of zero behaves as one
			if (st_ff.cnt + W'(1) >= limit) begin
				nxt_st.cnt = '0;
				nxt_st.pls = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			st_ff <= '0;
		else if (clk_en)
			st_ff <= nxt_st;
	end

	assign pulse = st_ff.pls;
endmodule

// file: rtl/gain_and_offset_cal_control.sv
// gain word and dc offset calibration control behind the three-wire serial port
// Behaviour
// R1 - programmed gain is the 5-bit field at bits 12..16 of register 1
// R2 - effective gain spans 0 to 24 in 1 dB steps
// R3 - effective gain is programmed gain minus the 3-bit fast-reduce pins
// R4 - subtraction below zero clamps to 0, never wraps
// R5 - register 1 bit 28 makes each pin count 2 dB instead of 1 dB
// R6 - register 2 bit 28 picks oscillator (1) or serial clock (0) for calibration
// R7 - 3-bit trim sets oscillator from about 300 kHz up to 1.8 MHz
// R8 - register 1 bit 29 drives the oscillator onto the readback pin
// R9 - 2-bit field sets correction converter full scale 50 to 200 uA
// R10 - register 2 bit 24 set drives converters from internal calibration registers
// R11 - internal I and Q correction registers start at 128
// R12 - writing bit 5 of register 2 starts a run; cleared when done
// R13 - host keeps local oscillator applied during an automatic run
// R14 - correction values held until power off or next run; a register 2 write with bit 24 clear also loads them
// R15 - two filter bits bypass detector resistor and capacitor
// R16 - calibration clock divided by ratio in register 2 bits 25..27
// R17 - run converges in nine divided calibration clock cycles
// R18 - manual mode: host writes 8-bit I and Q values, device applies them
// R19 - readback low bits give register, bank and 2-bit version
// R20 - readback bits 16..23 return current Q correction value
// R21 - readback bits 24..31 return current I correction value
// R22 - divider codes 0..7 give 1,8,16,128,256,1024,2048,16684
// R23 - fast-reduce pins used only while register 1 bit 27 set
module gain_and_offset_cal_control #(
	parameter logic [1:0] VERSION = 2'h2 // arbitrary version value
) (
	// clock, reset, clock enable
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// three-wire serial port
	input  wire logic       ser_clk,
	input  wire logic       ser_data,
	input  wire logic       ser_latch,
	output logic            readback_pin,
	// parallel fast gain reduction
	input  wire logic       fast_reduce_pin_msb,
	input  wire logic       fast_reduce_pin_mid,
	input  wire logic       fast_reduce_pin_lsb,
	// offset detector, high when correction is too large
	input  wire logic       i_offset_high,
	input  wire logic       q_offset_high,
	// analog controls
	output logic [4:0]      baseband_gain_word,
	output logic [7:0]      i_correction_value,
	output logic [7:0]      q_correction_value,
	output logic [1:0]      converter_fullscale_select,
	output logic            detector_resistor_bypass,
	output logic            detector_capacitor_bypass,
	output logic [2:0]      osc_trim_code,
	output logic            osc_out,
	output logic            cal_busy
);
	if (VERSION > 2'h3) begin : g_bad_version
		$error("version out of range");
	end

	typedef enum logic {
		CAL_IDLE,
		CAL_RUN
	} cal_state_t;

	typedef struct packed {
		logic [31:0] reg1;
		logic [31:0] reg2;
		logic [31:0] shift_in;
		logic [31:0] shift_out;
		logic        clk_d;
		logic        latch_d;
		logic [7:0]  i_cal;
		logic [7:0]  q_cal;
		logic [3:0]  step;
		cal_state_t  cal;
		logic        busy;
		logic        osc_lvl;
		logic [4:0]  gain;
		logic [7:0]  i_out;
		logic [7:0]  q_out;
		logic [1:0]  fs;
		logic        rbyp;
		logic        cbyp;
		logic [2:0]  trim;
		logic        rb_pin;
	} ctl_t;

	localparam ctl_t CTL_RESET = '{
		reg1:      cal_ctrl_pkg::REG1_RESET,
		reg2:      cal_ctrl_pkg::REG2_RESET,
		shift_in:  32'h0000_0000,
		shift_out: 32'h0000_0000,
		clk_d:     1'b0,
		latch_d:   1'b0,
		i_cal:     cal_ctrl_pkg::CORR_RESET,
		q_cal:     cal_ctrl_pkg::CORR_RESET,
		step:      4'h0,
		cal:       CAL_IDLE,
		busy:      1'b0,
		osc_lvl:   1'b0,
		gain:      5'h00,
		i_out:     cal_ctrl_pkg::CORR_RESET,
		q_out:     cal_ctrl_pkg::CORR_RESET,
		fs:        2'h0,
		rbyp:      1'b0,
		cbyp:      1'b0,
		trim:      3'h0,
		rb_pin:    1'b0
	};

	ctl_t st_ff;
	ctl_t nxt_st;

	// synchronised pins
	logic s_clk;
	logic s_data;
	logic s_latch;
	logic s_red_msb;
	logic s_red_mid;
	logic s_red_lsb;
	logic s_i_high;
	logic s_q_high;

	// time base
	logic                          osc_pulse;
	logic                          cal_tick;
	logic                          src_tick;
	logic                          run_start;
	logic [cal_ctrl_pkg::DIV_W-1:0] osc_half;
	logic [cal_ctrl_pkg::DIV_W-1:0] div_limit;

	pin_sync u_sync_clk   (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(ser_clk),
		.level(s_clk));
	pin_sync u_sync_data  (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(ser_data),
		.level(s_data));
	pin_sync u_sync_latch (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(ser_latch),
		.level(s_latch));
	pin_sync u_sync_msb   (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(fast_reduce_pin_msb),
		.level(s_red_msb));
	pin_sync u_sync_mid   (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(fast_reduce_pin_mid),
		.level(s_red_mid));
	pin_sync u_sync_lsb   (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(fast_reduce_pin_lsb),
		.level(s_red_lsb));
	pin_sync u_sync_idet  (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(i_offset_high),
		.level(s_i_high));
	pin_sync u_sync_qdet  (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pin(q_offset_high),
		.level(s_q_high));

	// oscillator model: trimmed half period of the system clock
	// limitation: the period is rounded down to whole system clocks
	assign osc_half = cal_ctrl_pkg::osc_half_cycles(st_ff.trim); // R7

	tick_divider #(.W(cal_ctrl_pkg::DIV_W)) u_osc (
		.sys_clk(sys_clk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.clear  (1'b0),
		.tick_in(1'b1),
		.limit  (osc_half),
		.pulse  (osc_pulse)
	);

	// calibration clock source: oscillator rising edge or serial clock rising edge
	// serial source only ticks while the host toggles it, so such a run
	// stalls when the host goes quiet
	assign src_tick = st_ff.reg2[cal_ctrl_pkg::CLK_SRC_BIT] ? (osc_pulse & ~st_ff.osc_lvl) // R6
		: (s_clk & ~st_ff.clk_d);
	assign div_limit = cal_ctrl_pkg::DIV_RATIO[st_ff.reg2[cal_ctrl_pkg::DIV_SEL_LSB +: 3]]; // R16 R22

	tick_divider #(.W(cal_ctrl_pkg::DIV_W)) u_cal_div (
		.sys_clk(sys_clk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.clear  (run_start),
		.tick_in(src_tick),
		.limit  (div_limit),
		.pulse  (cal_tick)
	);

	// a run starts from a serial write to register 2 with the trigger set
	// decoded from the word being latched, so the divider clears on the
	// same edge that enters the run
	always_comb begin
		run_start = s_latch && !st_ff.latch_d
			&& st_ff.shift_in[cal_ctrl_pkg::ADDR_LSB +: 3] == cal_ctrl_pkg::ADDR_REG2
			&& st_ff.shift_in[cal_ctrl_pkg::BANK_LSB +: 2] == cal_ctrl_pkg::BANK_MAIN
			&& st_ff.shift_in[cal_ctrl_pkg::TRIGGER_BIT]; // R12
	end

	always_comb begin
		logic [4:0] prog;
		logic [4:0] reduce;
		logic [4:0] diff;
		logic [2:0] bit_idx;
		logic       clk_rise;
		logic       clk_fall;
		logic       latch_rise;
		logic       wr1;
		logic       wr2;
		logic       rd0;
		prog       = '0;
		reduce     = '0;
		diff       = '0;
		bit_idx    = '0;
		nxt_st     = st_ff;
		clk_rise   = s_clk && !st_ff.clk_d;
		clk_fall   = !s_clk && st_ff.clk_d;
		latch_rise = s_latch && !st_ff.latch_d;
		wr1 = latch_rise && st_ff.shift_in[cal_ctrl_pkg::ADDR_LSB +: 3] == cal_ctrl_pkg::ADDR_REG1
			&& st_ff.shift_in[cal_ctrl_pkg::BANK_LSB +: 2] == cal_ctrl_pkg::BANK_MAIN;
		wr2 = latch_rise && st_ff.shift_in[cal_ctrl_pkg::ADDR_LSB +: 3] == cal_ctrl_pkg::ADDR_REG2
			&& st_ff.shift_in[cal_ctrl_pkg::BANK_LSB +: 2] == cal_ctrl_pkg::BANK_MAIN;
		rd0 = latch_rise && st_ff.shift_in[cal_ctrl_pkg::ADDR_LSB +: 3] == cal_ctrl_pkg::ADDR_RB;

		nxt_st.clk_d   = s_clk;
		nxt_st.latch_d = s_latch;
		if (osc_pulse)
			nxt_st.osc_lvl = !st_ff.osc_lvl;

		// serial word arrives bit 0 first
		if (clk_rise)
			nxt_st.shift_in = {s_data, st_ff.shift_in[31:1]};
		// readback bits change on the falling edge so the host samples on the rising one
		if (clk_fall)
			nxt_st.shift_out = {1'b0, st_ff.shift_out[31:1]};

		// automatic run: one settling tick, then one decided bit per tick
		unique case (st_ff.cal)
			CAL_IDLE: begin
			end
			CAL_RUN: begin
				if (cal_tick) begin
					nxt_st.step = st_ff.step + 4'h1;
					// limitation: at divide by one the detector path lags the trial bit
					if (st_ff.step != 4'h0) begin
						bit_idx = 3'(4'h8 - st_ff.step);
						// detector says too large: drop the trial bit
						if (s_i_high)
							nxt_st.i_cal[bit_idx] = 1'b0;
						if (s_q_high)
							nxt_st.q_cal[bit_idx] = 1'b0;
						if (bit_idx != 3'h0) begin
							nxt_st.i_cal[bit_idx - 3'h1] = 1'b1;
							nxt_st.q_cal[bit_idx - 3'h1] = 1'b1;
						end
					end
					if (st_ff.step + 4'h1 == cal_ctrl_pkg::CAL_STEPS) begin // R17
						nxt_st.cal = CAL_IDLE;
						nxt_st.reg2[cal_ctrl_pkg::TRIGGER_BIT] = 1'b0; // R12
					end
				end
			end
		endcase

		// host writes after completion so a fresh trigger wins over self-clear
		if (wr1)
			nxt_st.reg1 = st_ff.shift_in; // R1
		if (wr2) begin
			nxt_st.reg2 = st_ff.shift_in;
			if (!st_ff.shift_in[cal_ctrl_pkg::CAL_MODE_BIT]) begin
				nxt_st.i_cal = st_ff.shift_in[cal_ctrl_pkg::I_MAN_LSB +: 8]; // R18
				nxt_st.q_cal = st_ff.shift_in[cal_ctrl_pkg::Q_MAN_LSB +: 8]; // R18
			end
		end
		if (run_start) begin
			// restart from half scale; otherwise held until reset or a register 2 write with bit 24 clear
			nxt_st.cal   = CAL_RUN; // R12 R14
			nxt_st.step  = 4'h0;
			nxt_st.i_cal = cal_ctrl_pkg::CORR_RESET;
			nxt_st.q_cal = cal_ctrl_pkg::CORR_RESET;
		end
		nxt_st.busy = (nxt_st.cal == CAL_RUN); // R12

		// readback word: register, bank, version, Q and I values
		// codes captured at the latch; later changes show on the next read
		if (rd0) begin
			nxt_st.shift_out = cal_ctrl_pkg::RB_OFFSET;
			nxt_st.shift_out[cal_ctrl_pkg::ADDR_LSB +: 3]    = cal_ctrl_pkg::ADDR_RB; // R19
			nxt_st.shift_out[cal_ctrl_pkg::BANK_LSB +: 2]    = cal_ctrl_pkg::BANK_MAIN; // R19
			nxt_st.shift_out[cal_ctrl_pkg::VERSION_LSB +: 2] = VERSION; // R19
			nxt_st.shift_out[cal_ctrl_pkg::Q_RB_LSB +: 8]    = st_ff.q_out; // R20
			nxt_st.shift_out[cal_ctrl_pkg::I_RB_LSB +: 8]    = st_ff.i_out; // R21
		end

		// gain word
		prog   = st_ff.reg1[cal_ctrl_pkg::GAIN_LSB +: 5]; // R1
		// synchronised levels: a pin glitch shorter than two clocks is ignored
		reduce = {2'h0, s_red_msb, s_red_mid, s_red_lsb}; // R3
		if (st_ff.reg1[cal_ctrl_pkg::GAIN_X2_BIT])
			reduce = {reduce[3:0], 1'b0}; // R5
		if (!st_ff.reg1[cal_ctrl_pkg::EXT_RED_EN_BIT])
			reduce = 5'h00; // R23
		if (prog > reduce)
			diff = prog - reduce; // R3
		else
			diff = 5'h00; // R4
		// differences above the top of the range saturate, after the pin reduction
		if (diff > cal_ctrl_pkg::GAIN_MAX)
			diff = cal_ctrl_pkg::GAIN_MAX; // R2
		nxt_st.gain = diff;

		// converter drive: internal registers in auto mode, host fields in manual
		if (st_ff.reg2[cal_ctrl_pkg::CAL_MODE_BIT]) begin
			nxt_st.i_out = st_ff.i_cal; // R10
			nxt_st.q_out = st_ff.q_cal; // R10
		end else begin
			nxt_st.i_out = st_ff.reg2[cal_ctrl_pkg::I_MAN_LSB +: 8]; // R18
			nxt_st.q_out = st_ff.reg2[cal_ctrl_pkg::Q_MAN_LSB +: 8]; // R18
		end
		nxt_st.fs   = st_ff.reg2[cal_ctrl_pkg::FS_SEL_LSB +: 2]; // R9
		nxt_st.rbyp = st_ff.reg1[cal_ctrl_pkg::RES_BYP_BIT]; // R15
		nxt_st.cbyp = st_ff.reg1[cal_ctrl_pkg::CAP_BYP_BIT]; // R15
		nxt_st.trim = st_ff.reg2[cal_ctrl_pkg::OSC_TRIM_LSB +: 3]; // R7

		// probe mode steals the readback pin for the oscillator
		if (st_ff.reg1[cal_ctrl_pkg::OSC_PROBE_BIT])
			nxt_st.rb_pin = st_ff.osc_lvl; // R8
		else
			nxt_st.rb_pin = st_ff.shift_out[0];
	end

	// clk_en low holds every field, synchronisers included
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			st_ff <= CTL_RESET; // R11
		else if (clk_en)
			st_ff <= nxt_st;
	end

	assign readback_pin               = st_ff.rb_pin;
	assign baseband_gain_word         = st_ff.gain;
	assign i_correction_value         = st_ff.i_out;
	assign q_correction_value         = st_ff.q_out;
	assign converter_fullscale_select = st_ff.fs;
	assign detector_resistor_bypass   = st_ff.rbyp;
	assign detector_capacitor_bypass  = st_ff.cbyp;
	assign osc_trim_code              = st_ff.trim;
	assign osc_out                    = st_ff.osc_lvl;
	assign cal_busy                   = st_ff.busy;
endmodule

// file: tb/cal_ctrl_chk.sv
// port assertions of the gain and offset calibration control
module cal_ctrl_chk (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// serial latch and fast-reduce pins
	input wire logic       ser_latch,
	input wire logic       fast_reduce_pin_msb,
	input wire logic       fast_reduce_pin_mid,
	input wire logic       fast_reduce_pin_lsb,
	// observed outputs
	input wire logic [4:0] baseband_gain_word,
	input wire logic [7:0] i_correction_value,
	input wire logic [7:0] q_correction_value,
	input wire logic [1:0] converter_fullscale_select,
	input wire logic       detector_resistor_bypass,
	input wire logic       detector_capacitor_bypass,
	input wire logic [2:0] osc_trim_code,
	input wire logic       cal_busy
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] latch_age_ff;
	logic [3:0] act_age_ff;
	logic [3:0] pin_age_ff;
	logic [2:0] pins_ff;
	logic [2:0] pins;

	assign pins = {fast_reduce_pin_msb, fast_reduce_pin_mid, fast_reduce_pin_lsb};

	// ages saturate at 15; reset counts as recent so the reload after reset passes
	always_ff @(posedge sys_clk) begin
		pins_ff <= pins;
		latch_age_ff <= (!rst_n || ser_latch) ? 4'h0 : latch_age_ff + {3'h0, latch_age_ff != 4'hF};
		act_age_ff <= (!rst_n || ser_latch || cal_busy) ? 4'h0 : act_age_ff + {3'h0, act_age_ff != 4'hF};
		pin_age_ff <= (!rst_n || pins != pins_ff) ? 4'h0 : pin_age_ff + {3'h0, pin_age_ff != 4'hF};
	end

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_gain_ceiling: assert property (baseband_gain_word <= 5'h18)
		else $error("gain word above 24");
	a_gain_cause: assert property ($changed(baseband_gain_word) |-> latch_age_ff < 4'hC || pin_age_ff < 4'hC)
		else $error("gain word moved without write or pin change");
	a_fs_cause: assert property ($changed(converter_fullscale_select) |-> latch_age_ff < 4'hC)
		else $error("full scale moved without write");
	a_trim_cause: assert property ($changed(osc_trim_code) |-> latch_age_ff < 4'hC)
		else $error("trim moved without write");
	a_bypass_cause: assert property ($changed({detector_resistor_bypass, detector_capacitor_bypass})
		|-> latch_age_ff < 4'hC)
		else $error("filter bypass moved without write");
	a_i_hold_idle: assert property ($changed(i_correction_value) |-> act_age_ff < 4'hC)
		else $error("i code moved while idle");
	a_q_hold_idle: assert property ($changed(q_correction_value) |-> act_age_ff < 4'hC)
		else $error("q code moved while idle");
	a_run_start: assert property ($rose(cal_busy) |-> latch_age_ff < 4'h8)
		else $error("run began without a write");
	a_run_min: assert property ($rose(cal_busy) |=> cal_busy [*8])
		else $error("run ended too soon");

	cover property ($fell(cal_busy));
	cover property (baseband_gain_word == 5'h00 && pin_age_ff == 4'hF);
	cover property ($changed(i_correction_value) && !cal_busy);
endmodule

bind gain_and_offset_cal_control cal_ctrl_chk i_chk (
	.sys_clk                    (sys_clk),
	.rst_n                      (rst_n),
	.ser_latch                  (ser_latch),
	.fast_reduce_pin_msb        (fast_reduce_pin_msb),
	.fast_reduce_pin_mid        (fast_reduce_pin_mid),
	.fast_reduce_pin_lsb        (fast_reduce_pin_lsb),
	.baseband_gain_word         (baseband_gain_word),
	.i_correction_value         (i_correction_value),
	.q_correction_value         (q_correction_value),
	.converter_fullscale_select (converter_fullscale_select),
	.detector_resistor_bypass   (detector_resistor_bypass),
	.detector_capacitor_bypass  (detector_capacitor_bypass),
	.osc_trim_code              (osc_trim_code),
	.cal_busy                   (cal_busy)
);

// file: tb/ser_host.sv
// serial host model: shifts words in, latches them, reads the readback pin
module ser_host (
	// clock
	input  wire logic sys_clk,
	// serial port
	output logic      ser_clk,
	output logic      ser_data,
	output logic      ser_latch,
	input  wire logic readback_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_latch = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// five cycles high and low, beyond the two the pin filter needs
	task automatic pulse(input int n);
		repeat (n) begin
			wait_clk(5);
			ser_clk <= 1'b1;
			wait_clk(5);
			ser_clk <= 1'b0;
		end
	endtask

	// bit 0 first, latch only with the clock at rest
	task automatic send(input logic [31:0] w);
		for (int i = 0; i < 32; i++) begin
			@(posedge sys_clk);
			ser_data <= w[i];
			pulse(1);
		end
		wait_clk(5);
		ser_latch <= 1'b1;
		wait_clk(5);
		ser_latch <= 1'b0;
		ser_data <= ~ser_data;
		wait_clk(5);
	endtask

	// readback command, then one bit per falling serial clock
	task automatic read(output logic [31:0] w);
		send(32'h0000_0000);
		for (int i = 0; i < 32; i++) begin
			@(negedge sys_clk);
			w[i] = readback_pin;
			pulse(1);
			wait_clk(7);
		end
	endtask
endmodule

// file: tb/gain_and_offset_cal_control_tb.sv
// self-checking bench of the gain and offset calibration control
module gain_and_offset_cal_control_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [1:0] VER = 2'h3; // arbitrary version value
	localparam int RATIO [8] = '{1, 8, 16, 128, 256, 1024, 2048, 16684};

	logic       sys_clk, rst_n, clk_en, ser_clk, ser_data, ser_latch, rb_pin;
	logic [2:0] pins, trim;
	logic       i_hi, q_hi, res_byp, cap_byp, osc_out, busy;
	logic [4:0] gain;
	logic [7:0] i_code, q_code, i_tgt, q_tgt;
	logic [1:0] fs;
	int         fails, tests_run;

	gain_and_offset_cal_control #(.VERSION(VER)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch), .readback_pin(rb_pin),
		.fast_reduce_pin_msb(pins[2]), .fast_reduce_pin_mid(pins[1]), .fast_reduce_pin_lsb(pins[0]),
		.i_offset_high(i_hi), .q_offset_high(q_hi), .baseband_gain_word(gain),
		.i_correction_value(i_code), .q_correction_value(q_code), .converter_fullscale_select(fs),
		.detector_resistor_bypass(res_byp), .detector_capacitor_bypass(cap_byp),
		.osc_trim_code(trim), .osc_out(osc_out), .cal_busy(busy)
	);

	ser_host i_host (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
		.readback_pin(rb_pin));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// detector with the local oscillator applied throughout: high when a code overshoots
	always @(posedge sys_clk) begin
		i_hi <= i_code > i_tgt;
		q_hi <= q_code > q_tgt;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results;
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wait_idle(output int len);
		len = 0;
		while (busy !== 1'b0) begin
			@(negedge sys_clk);
			len++;
			if (len > 40000) begin
				fails++;
				results();
			end
		end
	endtask

	function automatic logic [4:0] exp_gain(input int g, input logic en, input logic x2, input int p);
		int r;
		r = g - (en ? p * (x2 ? 2 : 1) : 0);
		if (r < 0)
			r = 0;
		return r[4:0];
	endfunction

	function automatic int osc_half(input int t);
		int khz [8] = '{300, 500, 700, 900, 1100, 1300, 1500, 1800};
		return 10000 / (2 * khz[t]);
	endfunction

	function automatic logic [31:0] w1(input logic [4:0] g, input logic res, cap, en, x2, probe);
		return {2'h0, probe, x2, en, cap, res, 8'h80, g, 12'hC89};
	endfunction

	function automatic logic [31:0] w2(input logic [2:0] t, input logic src, input logic [2:0] d,
		input logic mode, input logic [1:0] f, input logic [7:0] q, i, input logic trig);
		return {t, src, d, mode, f, q, i, trig, 5'h0A};
	endfunction

	function automatic logic [31:0] rb(input logic [7:0] i, q);
		return {i, q, 9'h000, VER, 5'h08};
	endfunction

	initial begin
		logic [31:0] w;
		logic [7:0]  mi, mq;
		logic        en, x2, prev, po;
		int          g, p, n, m, len;
		rst_n = 1'b0;
		clk_en = 1'b1;
		pins = 3'h0;
		i_hi = 1'b0;
		q_hi = 1'b0;
		i_tgt = 8'h00;
		q_tgt = 8'h00;
		fails = 0;
		tests_run = 0;
		void'($urandom(61830));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		i_host.wait_clk(6);
		chk("gain", 5'h0F, gain);
		chk("i code", 8'h80, i_code);
		chk("q code", 8'h80, q_code);
		chk("full scale", 2'h3, fs);
		i_host.read(w);
		chk("readback", rb(8'h80, 8'h80), w);
		// a write while the clock enable is low must leave no trace
		@(posedge sys_clk);
		clk_en <= 1'b0;
		i_host.send(w1(5'h05, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
		@(posedge sys_clk);
		clk_en <= 1'b1;
		i_host.wait_clk(6);
		chk("gain", 5'h0F, gain);
		for (int k = 0; k < 12; k++) begin
			g = (k == 0) ? 3 : (k == 1) ? 24 : $urandom_range(24);
			p = (k < 2) ? 7 : $urandom_range(7);
			en = (k < 2) || ($urandom_range(1) == 1);
			x2 = (k == 1) || ($urandom_range(1) == 1);
			@(posedge sys_clk);
			pins <= p[2:0];
			i_host.send(w1(g[4:0], k[0], k[1], en, x2, 1'b0));
			i_host.wait_clk(4);
			chk("gain", exp_gain(g, en, x2, p), gain);
			chk("bypass", {k[1], k[0]}, {cap_byp, res_byp});
		end
		i_host.send(w1(5'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
		for (int t = 0; t < 8; t++) begin
			mi = $urandom;
			mq = $urandom;
			i_host.send(w2(t[2:0], 1'b1, 3'h0, 1'b0, t[1:0], mq, mi, 1'b0));
			chk("trim", t[2:0], trim);
			chk("full scale", t[1:0], fs);
			chk("i code", mi, i_code);
			chk("q code", mq, q_code);
			n = 0;
			m = 0;
			@(negedge sys_clk);
			prev = rb_pin;
			po = osc_out;
			repeat (400) begin
				@(negedge sys_clk);
				n += (rb_pin && !prev) ? 1 : 0;
				m += (osc_out && !po) ? 1 : 0;
				prev = rb_pin;
				po = osc_out;
			end
			p = 400 / (2 * osc_half(t));
			chk("osc rises", 1'b1, n >= p - 1 && n <= p + 1);
			chk("osc out rises", 1'b1, m >= p - 1 && m <= p + 1);
		end
		i_host.send(w1(5'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
		i_host.read(w);
		chk("readback", rb(mi, mq), w);
		for (int d = 0; d < 5; d++) begin
			i_tgt = $urandom;
			q_tgt = $urandom;
			i_host.send(w2(3'h7, 1'b1, d[2:0], 1'b1, 2'h0, 8'h00, 8'h00, 1'b1));
			chk("busy", 1'b1, busy);
			wait_idle(len);
			p = 36 * RATIO[d];
			chk("run length", 1'b1, len >= p - 12 && len <= p + 4);
			i_host.wait_clk(3);
			if (d > 0) begin
				chk("i result", i_tgt, i_code);
				chk("q result", q_tgt, q_code);
			end
		end
		i_host.send(w1(5'h10, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
		i_host.read(w);
		chk("readback", rb(i_tgt, q_tgt), w);
		i_host.send(w2(3'h7, 1'b0, 3'h0, 1'b1, 2'h0, 8'h00, 8'h00, 1'b1));
		i_host.wait_clk(200);
		chk("busy", 1'b1, busy);
		i_host.pulse(12);
		i_host.wait_clk(8);
		chk("busy", 1'b0, busy);
		results();
	end
endmodule
